// ### bench/host_model.sv
`timescale 1ns/1ns
module host_model (
	input wire logic clk_sys,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end

	// The strobe stands for one cycle; data is scrambled once it is no longer valid.
	task automatic write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_sys);
		#1;
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~data;
	endtask : write

	task automatic read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_sys);
		#1;
		reg_addr = addr;
		@(posedge clk_sys);
		@(posedge clk_sys);
		#1;
		data = reg_rdata;
	endtask : read

	// Outputs that are never started go out with their enable bit cleared.
	function automatic logic [7:0] safe_enables(input logic [7:0] en, input logic [5:0] no_start);
		return {en[7:6], en[5:0] & ~no_start};
	endfunction : safe_enables
endmodule : host_model

// ### bench/tb_regulator_control_registers.sv
`timescale 1ns/1ns
module tb_regulator_control_registers;
	logic clk_sys, arst_n, enable_pin, voltage_select_pin, overheat_pin, cooled_pin;
	logic warning_pin, sleep_by_pin, voltage_select_by_pin, short_step_select, reg_wr;
	logic force_pwm, switcher_external, sleep_active, overheat_shutdown_flag;
	logic overheat_warning_flag;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, status_exp;
	logic [5:0] rail_on, rail_discharge;
	logic [5:0][8:0] rail_level;
	logic [4:0] switcher_code;
	logic [7:0] cfg [9];
	int mismatches, samples_checked, a;
	integer seed;
	localparam logic [2:0] SEQ_DLY [6] = '{3'h0, 3'h3, 3'h6, 3'h7, 3'h1, 3'h2};

	host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	regulator_control_registers uut (.clk_sys(clk_sys), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.enable_pin(enable_pin), .voltage_select_pin(voltage_select_pin),
		.overheat_pin(overheat_pin), .cooled_pin(cooled_pin), .warning_pin(warning_pin),
		.sleep_by_pin(sleep_by_pin), .voltage_select_by_pin(voltage_select_by_pin),
		.short_step_select(short_step_select), .rail_on(rail_on),
		.rail_discharge(rail_discharge), .rail_level(rail_level), .force_pwm(force_pwm),
		.switcher_code(switcher_code), .switcher_external(switcher_external),
		.sleep_active(sleep_active), .overheat_shutdown_flag(overheat_shutdown_flag),
		.overheat_warning_flag(overheat_warning_flag));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	task automatic cfg_reset();
		for (int i = 0; i < 9; i++) cfg[i] = regctl_pkg::CFG_DEFAULT[i];
	endtask : cfg_reset

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		host.write(addr, data);
		if (addr >= 8'h01 && addr <= 8'h09) cfg[addr-1] = data & regctl_pkg::CFG_WMASK[addr-1];
	endtask : wr

	function automatic logic [7:0] exp_read(input int adr);
		if (adr >= 1 && adr <= 9) return cfg[adr-1];
		return (adr == 10) ? status_exp : 8'h00;
	endfunction : exp_read

	function automatic logic [5:0] exp_rails(input int k);
		logic [5:0] r;
		for (int i = 0; i < 6; i++)
			r[i] = cfg[7][i] && cfg[i][7:5] != 3'h7 && int'(cfg[i][7:5]) <= k;
		return r;
	endfunction : exp_rails

	task automatic read_all();
		for (int i = 0; i < 12; i++) begin
			host.read(8'(i), rd);
			check(rd, exp_read(i));
		end
	endtask : read_all

	task automatic check_outputs();
		logic [4:0] code;
		for (int i = 0; i < 5; i++)
			check(rail_level[i], i == 3 ? regctl_pkg::LOW_TABLE[cfg[3][4:0]] :
				regctl_pkg::MAIN_TABLE[cfg[i][4:0]]);
		code = (voltage_select_by_pin ? voltage_select_pin : cfg[7][7]) ? cfg[5][4:0] : cfg[6][4:0];
		check(switcher_code, code);
		check(switcher_external, code == 5'h00);
		if (code != 5'h00)
			check(rail_level[5], regctl_pkg::SWITCHER_BASE + regctl_pkg::SWITCHER_STEP * code);
		check(rail_discharge, cfg[8][5:0]);
		check(force_pwm, cfg[6][4]);
	endtask : check_outputs

	task automatic run_seq(input int step);
		int n;
		n = 0;
		while (rail_on[0] !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		check(n < 200, 1'b1);
		tick(step / 2);
		for (int k = 0; k < 7; k++) begin
			check(rail_on, exp_rails(k));
			tick(step);
		end
		check(rail_on, cfg[7][5:0]);
	endtask : run_seq

	// The scenarios need about thirty thousand cycles; the limit allows twice that.
	initial begin
		#1200000;
		mismatches++;
		final_report();
	end

	initial begin
		seed = 32'h7c265457;
		{arst_n, enable_pin, voltage_select_pin, overheat_pin, cooled_pin, warning_pin} = 6'h00;
		{sleep_by_pin, voltage_select_by_pin, short_step_select} = 3'h0;
		mismatches = 0;
		samples_checked = 0;
		status_exp = 8'h00;
		cfg_reset();
		tick(6);
		arst_n = 1'b1;
		tick(4);
		read_all();
		check(rail_on, 6'h00);
		for (int i = 0; i < 40; i++) begin
			{voltage_select_by_pin, voltage_select_pin} = 2'($random(seed));
			a = 1 + ($unsigned($random(seed)) % 11);
			wr(8'(a), 8'($random(seed)));
			host.read(8'(a), rd);
			check(rd, exp_read(a));
			check_outputs();
		end
		voltage_select_by_pin = 1'b0;
		for (int i = 0; i < 6; i++) wr(8'(i + 1), {SEQ_DLY[i], 5'($random(seed) | 1)});
		wr(regctl_pkg::ADDR_ENABLES, host.safe_enables(8'h3f, 6'h08));
		wr(regctl_pkg::ADDR_DISCHARGE, 8'h80 | 8'($random(seed) & 8'h3f));
		wr(regctl_pkg::ADDR_BUCK2, 8'h10);
		check_outputs();
		enable_pin = 1'b1;
		run_seq(regctl_pkg::STEP_LONG_CYC);
		for (int i = 0; i < 3; i++) begin
			wr(regctl_pkg::ADDR_ENABLES, host.safe_enables(8'($random(seed)), 6'h08));
			tick(1);
			check(rail_on, cfg[7][5:0]);
		end
		for (int m = 0; m < 4; m++) begin
			sleep_by_pin = m[1];
			voltage_select_pin = m[0];
			wr(regctl_pkg::ADDR_ENABLES, {1'b0, m[0] == 1, 6'h37});
			tick(4);
			check(sleep_active, m[1] ? m[0] == 0 : m[0] == 1);
		end
		sleep_by_pin = 1'b0;
		warning_pin = 1'b1;
		status_exp = 8'h01;
		tick(4);
		check(overheat_warning_flag, 1'b1);
		read_all();
		warning_pin = 1'b0;
		overheat_pin = 1'b1;
		status_exp = 8'h02;
		tick(4);
		check(overheat_shutdown_flag, 1'b1);
		check(rail_on, 6'h00);
		wr(regctl_pkg::ADDR_STATUS, 8'h00);
		read_all();
		short_step_select = 1'b1;
		overheat_pin = 1'b0;
		cooled_pin = 1'b1;
		status_exp = 8'h00;
		run_seq(regctl_pkg::STEP_SHORT_CYC);
		read_all();
		wr(regctl_pkg::ADDR_DISCHARGE, 8'h15);
		cooled_pin = 1'b0;
		overheat_pin = 1'b1;
		tick(4);
		overheat_pin = 1'b0;
		cooled_pin = 1'b1;
		tick(20);
		cfg_reset();
		read_all();
		check_outputs();
		check(overheat_shutdown_flag, 1'b0);
		final_report();
	end
endmodule : tb_regulator_control_registers

// ### verilog/regctl_pkg.sv
package regctl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_REG1 = 8'h01;
	localparam logic [7:0] ADDR_BUCK1 = 8'h06;
	localparam logic [7:0] ADDR_BUCK2 = 8'h07;
	localparam logic [7:0] ADDR_ENABLES = 8'h08;
	localparam logic [7:0] ADDR_DISCHARGE = 8'h09;
	localparam logic [7:0] ADDR_STATUS = 8'h0a;
	localparam int CFG_COUNT = 9;
	localparam logic [3:0] IDX_BUCK1 = 4'h5;
	localparam logic [3:0] IDX_BUCK2 = 4'h6;
	localparam logic [3:0] IDX_ENABLES = 4'h7;
	localparam logic [3:0] IDX_DISCHARGE = 4'h8;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int DELAY_HI = 7;
	localparam int DELAY_LO = 5;
	localparam int CODE_HI = 4;
	localparam int FORCE_PWM_BIT = 4;
	localparam int SLEEP_BIT = 6;
	localparam int SELECT_BIT = 7;
	localparam int KEEP_BIT = 7;
	localparam int RAILS = 6;
	localparam int SWITCHER_RAIL = 5;
	localparam int LOW_TABLE_RAIL = 3;
	localparam logic [2:0] DELAY_NONE = 3'h0;
	localparam logic [2:0] DELAY_NO_START = 3'h7;
	localparam logic [2:0] LAST_STEP = 3'h6;

	// Reset values of the configuration bytes, addresses 0x01 to 0x09.
	localparam logic [CFG_COUNT-1:0][7:0] CFG_DEFAULT = {
		8'h3f, 8'h8f, 8'h05, 8'he5, 8'hff, 8'h63, 8'h6c, 8'h75, 8'h7d};
	// Writable bits; the others are reserved and read as zero.
	localparam logic [CFG_COUNT-1:0][7:0] CFG_WMASK = {
		8'hbf, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

	// ----------------------------------------------------------------
	// Synchronised pin bits
	// ----------------------------------------------------------------
	localparam int PIN_EN = 4;
	localparam int PIN_VSEL = 3;
	localparam int PIN_HOT = 2;
	localparam int PIN_COOL = 1;
	localparam int PIN_WARN = 0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int STEP_SHORT_US = 25;
	localparam int STEP_LONG_US = 50;
	localparam logic [11:0] STEP_SHORT_CYC = 12'(STEP_SHORT_US * CLK_MHZ);
	localparam logic [11:0] STEP_LONG_CYC = 12'(STEP_LONG_US * CLK_MHZ);

	// ----------------------------------------------------------------
	// Voltage tables, in units of 10 mV
	// ----------------------------------------------------------------
	localparam logic [8:0] MAIN_TABLE [32] = '{
		9'h078, 9'h07d, 9'h082, 9'h087, 9'h08c, 9'h091, 9'h096, 9'h09b,
		9'h0a0, 9'h0a5, 9'h0aa, 9'h0af, 9'h0b4, 9'h0b9, 9'h0be, 9'h0c8,
		9'h0d2, 9'h0dc, 9'h0e6, 9'h0f0, 9'h0fa, 9'h104, 9'h109, 9'h10e,
		9'h113, 9'h118, 9'h11d, 9'h122, 9'h127, 9'h12c, 9'h136, 9'h14a};
	localparam logic [8:0] LOW_TABLE [32] = '{
		9'h050, 9'h055, 9'h05a, 9'h064, 9'h06e, 9'h078, 9'h07d, 9'h082,
		9'h087, 9'h08c, 9'h091, 9'h096, 9'h09b, 9'h0a0, 9'h0a5, 9'h0aa,
		9'h0af, 9'h0b4, 9'h0b9, 9'h0be, 9'h0c8, 9'h0d2, 9'h0dc, 9'h0e6,
		9'h0f0, 9'h0fa, 9'h104, 9'h109, 9'h10e, 9'h113, 9'h118, 9'h11d};
	localparam logic [8:0] SWITCHER_BASE = 9'h04b;
	localparam logic [8:0] SWITCHER_STEP = 9'h005;
	localparam logic [4:0] SWITCHER_EXT_CODE = 5'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TBL_MAIN, TBL_LOW, TBL_SWITCHER} table_e;
	typedef enum logic [1:0] {ST_STANDBY, ST_STARTUP, ST_IDLE, ST_OVERHEAT} power_e;

endpackage : regctl_pkg

// ### verilog/regulator_control_registers.sv
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Outputs one, two, three, five decode 5-bit codes 1.20V to 3.30V.
// R2 - Output four decodes its code on a separate 0.80V to 2.85V table.
// R3 - Switcher codes step 50 mV from 0.80V; code zero selects external divider.
// R4 - Delay 000 none, 001-110 that many steps, 111 never started.
// R5 - Host should clear the enable bit of any never-started output.
// R6 - Force bit 1 means fixed pulse-width; 0 means automatic mode choice.
// R7 - In standby, enable bits choose which outputs the next startup turns on.
// R8 - In idle, enable bit writes switch outputs on or off at once.
// R9 - Software sleep bit acts only while sleep pin control is off.
// R10 - Software select bit picks code a or b only without pin control.
// R11 - Each output and the switcher have their own discharge bit.
// R12 - After overheat and cooling, startup restarts itself if enable pin high.
// R13 - Keep bit 0 restores defaults before that restart; 1 keeps contents.
// R14 - Status register shows overheat shutdown; writes to it do nothing.
// R15 - Status register shows overheat warning while above its threshold.
// R16 - Startup time step is 25 us when short step set, else 50 us.
// R17 - With pin select, high pin picks code a, low pin picks code b.
// R18 - With pin sleep, high select pin means normal, low means sleep.
module regulator_control_registers (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic enable_pin,
	input wire logic voltage_select_pin,
	input wire logic overheat_pin,
	input wire logic cooled_pin,
	input wire logic warning_pin,
	input wire logic sleep_by_pin,
	input wire logic voltage_select_by_pin,
	input wire logic short_step_select,
	output logic [5:0] rail_on,
	output logic [5:0] rail_discharge,
	output logic [5:0][8:0] rail_level,
	output logic force_pwm,
	output logic [4:0] switcher_code,
	output logic switcher_external,
	output logic sleep_active,
	output logic overheat_shutdown_flag,
	output logic overheat_warning_flag
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [regctl_pkg::CFG_COUNT-1:0][7:0] cfg;
		regctl_pkg::power_e st;
		logic [2:0] step;
		logic [11:0] tick;
		logic [4:0] pin_meta;
		logic [4:0] pin_sync;
		logic [7:0] rdata;
	} state_s;

	state_s cur_ff;
	state_s nxt_ff;
	logic [3:0] wr_idx;
	logic cfg_hit;
	logic restart_now;
	logic [11:0] step_cyc;
	logic [5:0] never_start;
	logic [5:0] too_early;
	logic [5:0] rail_en;
	logic select_a;

	always_comb begin
		nxt_ff = cur_ff;
		wr_idx = 4'(reg_addr - regctl_pkg::ADDR_REG1);
		cfg_hit = (reg_addr >= regctl_pkg::ADDR_REG1) && (reg_addr <= regctl_pkg::ADDR_DISCHARGE);
		step_cyc = short_step_select ? regctl_pkg::STEP_SHORT_CYC
			: regctl_pkg::STEP_LONG_CYC; // R16
		rail_en = cur_ff.cfg[regctl_pkg::IDX_ENABLES][5:0];
		restart_now = 1'b0;
		nxt_ff.pin_meta = {enable_pin, voltage_select_pin, overheat_pin, cooled_pin, warning_pin};
		nxt_ff.pin_sync = cur_ff.pin_meta;

		// Writes to the status address fall outside the window and are dropped.
		if (reg_wr && cfg_hit) begin // R14
			nxt_ff.cfg[wr_idx] = reg_wdata & regctl_pkg::CFG_WMASK[wr_idx];
		end

		if (cur_ff.pin_sync[regctl_pkg::PIN_HOT]) begin
			nxt_ff.st = regctl_pkg::ST_OVERHEAT;
		end else begin
			unique case (cur_ff.st)
				regctl_pkg::ST_STANDBY: begin
					if (cur_ff.pin_sync[regctl_pkg::PIN_EN]) begin
						nxt_ff.st = regctl_pkg::ST_STARTUP;
						nxt_ff.step = 3'h0;
						nxt_ff.tick = 12'h000;
					end
				end
				regctl_pkg::ST_STARTUP: begin
					if (!cur_ff.pin_sync[regctl_pkg::PIN_EN]) begin
						nxt_ff.st = regctl_pkg::ST_STANDBY;
					end else if (cur_ff.tick >= step_cyc - 12'h001) begin // R16
						nxt_ff.tick = 12'h000;
						if (cur_ff.step == regctl_pkg::LAST_STEP) begin
							nxt_ff.st = regctl_pkg::ST_IDLE;
						end else begin
							nxt_ff.step = cur_ff.step + 3'h1;
						end
					end else begin
						nxt_ff.tick = cur_ff.tick + 12'h001;
					end
				end
				regctl_pkg::ST_IDLE: begin
					if (!cur_ff.pin_sync[regctl_pkg::PIN_EN]) begin
						nxt_ff.st = regctl_pkg::ST_STANDBY;
					end
				end
				regctl_pkg::ST_OVERHEAT: begin
					if (cur_ff.pin_sync[regctl_pkg::PIN_COOL]) begin
						if (cur_ff.pin_sync[regctl_pkg::PIN_EN]) begin
							restart_now = 1'b1;
							nxt_ff.st = regctl_pkg::ST_STARTUP; // R12
							nxt_ff.step = 3'h0;
							nxt_ff.tick = 12'h000;
							if (!cur_ff.cfg[regctl_pkg::IDX_DISCHARGE][regctl_pkg::KEEP_BIT]) begin
								nxt_ff.cfg = regctl_pkg::CFG_DEFAULT; // R13
							end
						end else begin
							nxt_ff.st = regctl_pkg::ST_STANDBY;
						end
					end
				end
			endcase
		end

		// Per-rail startup placement; rail 5 is the switcher in byte 0x06.
		for (int i = 0; i < regctl_pkg::RAILS; i++) begin
			never_start[i] = cur_ff.cfg[i][regctl_pkg::DELAY_HI:regctl_pkg::DELAY_LO]
				== regctl_pkg::DELAY_NO_START; // R4
			too_early[i] = cur_ff.step
				< cur_ff.cfg[i][regctl_pkg::DELAY_HI:regctl_pkg::DELAY_LO]; // R4
		end

		if (cfg_hit) begin
			nxt_ff.rdata = cur_ff.cfg[wr_idx];
		end else if (reg_addr == regctl_pkg::ADDR_STATUS) begin
			nxt_ff.rdata = {6'h00, cur_ff.st == regctl_pkg::ST_OVERHEAT,
				cur_ff.pin_sync[regctl_pkg::PIN_WARN]}; // R14 R15
		end else begin
			nxt_ff.rdata = 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cur_ff <= '{cfg: regctl_pkg::CFG_DEFAULT, st: regctl_pkg::ST_STANDBY,
				step: 3'h0, tick: 12'h000, pin_meta: 5'h00, pin_sync: 5'h00, rdata: 8'h00};
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		unique case (cur_ff.st)
			regctl_pkg::ST_STARTUP: rail_on = rail_en & ~never_start & ~too_early; // R4 R7
			regctl_pkg::ST_IDLE: rail_on = rail_en; // R8
			default: rail_on = 6'h00;
		endcase
	end

	assign select_a = voltage_select_by_pin ? cur_ff.pin_sync[regctl_pkg::PIN_VSEL]
		: cur_ff.cfg[regctl_pkg::IDX_ENABLES][regctl_pkg::SELECT_BIT]; // R10 R17
	assign switcher_code = select_a ? cur_ff.cfg[regctl_pkg::IDX_BUCK1][regctl_pkg::CODE_HI:0]
		: cur_ff.cfg[regctl_pkg::IDX_BUCK2][regctl_pkg::CODE_HI:0];
	assign sleep_active = (cur_ff.st == regctl_pkg::ST_IDLE) && (sleep_by_pin
		? !cur_ff.pin_sync[regctl_pkg::PIN_VSEL]
		: cur_ff.cfg[regctl_pkg::IDX_ENABLES][regctl_pkg::SLEEP_BIT]); // R9 R18
	assign force_pwm = cur_ff.cfg[regctl_pkg::IDX_BUCK2][regctl_pkg::FORCE_PWM_BIT]; // R6
	assign rail_discharge = cur_ff.cfg[regctl_pkg::IDX_DISCHARGE][5:0]; // R11
	assign overheat_shutdown_flag = (cur_ff.st == regctl_pkg::ST_OVERHEAT); // R14
	assign overheat_warning_flag = cur_ff.pin_sync[regctl_pkg::PIN_WARN]; // R15
	assign reg_rdata = cur_ff.rdata;

	// ----------------------------------------------------------------
	// Voltage decoders
	// ----------------------------------------------------------------
	for (genvar g = 0; g < regctl_pkg::RAILS; g++) begin : g_rail
		voltage_if vif();
		if (g == regctl_pkg::SWITCHER_RAIL) begin : g_sw
			assign vif.code = switcher_code;
			assign vif.table_sel = regctl_pkg::TBL_SWITCHER;
			assign switcher_external = vif.external;
		end else begin : g_ldo
			assign vif.code = cur_ff.cfg[g][regctl_pkg::CODE_HI:0];
			assign vif.table_sel = (g == regctl_pkg::LOW_TABLE_RAIL)
				? regctl_pkg::TBL_LOW : regctl_pkg::TBL_MAIN;
		end
		assign rail_level[g] = vif.level;
		voltage_decode u_dec (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.vif(vif)
		);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence restart_s;
		cur_ff.st == regctl_pkg::ST_OVERHEAT && !cur_ff.pin_sync[regctl_pkg::PIN_HOT]
			&& cur_ff.pin_sync[regctl_pkg::PIN_COOL] && cur_ff.pin_sync[regctl_pkg::PIN_EN];
	endsequence
	sequence idle_write_s;
		cur_ff.st == regctl_pkg::ST_IDLE && reg_wr && reg_addr == regctl_pkg::ADDR_ENABLES
			##1 cur_ff.st == regctl_pkg::ST_IDLE;
	endsequence

	no_start_a: assert property ( // R4
		(rail_on & never_start & {6{cur_ff.st == regctl_pkg::ST_STARTUP}}) == 6'h00)
		else $error("never-started rail turned on");
	delay_order_a: assert property ( // R4
		(cur_ff.st == regctl_pkg::ST_STARTUP) |-> (rail_on & too_early) == 6'h00)
		else $error("rail turned on before its delay slot");
	idle_enable_a: assert property ( // R8
		idle_write_s |-> rail_on == $past(reg_wdata[5:0]))
		else $error("idle enable write not applied at once");
	pwm_write_a: assert property ( // R6
		reg_wr && reg_addr == regctl_pkg::ADDR_BUCK2 && !restart_now
		|=> force_pwm == $past(reg_wdata[4]))
		else $error("force bit not taken");
	soft_select_a: assert property ( // R10
		!voltage_select_by_pin |-> switcher_code == (cur_ff.cfg[7][7]
		? cur_ff.cfg[5][4:0] : cur_ff.cfg[6][4:0]))
		else $error("software voltage select wrong");
	// The pin is compared two edges late, the latency of its synchroniser.
	pin_select_a: assert property ( // R17
		voltage_select_by_pin && $past(rst_n, 2)
		|-> switcher_code == ($past(voltage_select_pin, 2) ? cur_ff.cfg[5][4:0]
		: cur_ff.cfg[6][4:0]))
		else $error("pin voltage select wrong");
	sleep_soft_a: assert property ( // R9
		!sleep_by_pin && cur_ff.st == regctl_pkg::ST_IDLE |-> sleep_active == cur_ff.cfg[7][6])
		else $error("software sleep wrong");
	sleep_pin_a: assert property ( // R18
		sleep_by_pin && cur_ff.st == regctl_pkg::ST_IDLE
		|-> sleep_active != cur_ff.pin_sync[regctl_pkg::PIN_VSEL])
		else $error("pin sleep wrong");
	restart_a: assert property ( // R12
		restart_s |=> cur_ff.st == regctl_pkg::ST_STARTUP && cur_ff.step == 3'h0)
		else $error("no restart after cooling");
	clear_regs_a: assert property ( // R13
		restart_s ##0 !cur_ff.cfg[8][7] |=> cur_ff.cfg == regctl_pkg::CFG_DEFAULT)
		else $error("registers not restored before restart");
	keep_regs_a: assert property ( // R13
		restart_s ##0 cur_ff.cfg[8][7] && !reg_wr |=> $stable(cur_ff.cfg))
		else $error("registers changed despite keep bit");
	status_ro_a: assert property ( // R14
		reg_wr && reg_addr == regctl_pkg::ADDR_STATUS && !restart_now |=> $stable(cur_ff.cfg))
		else $error("status write changed state");
	status_read_a: assert property ( // R14 R15
		reg_addr == regctl_pkg::ADDR_STATUS |=> reg_rdata
		== {6'h00, $past(overheat_shutdown_flag), $past(overheat_warning_flag)})
		else $error("status readback wrong");
	discharge_a: assert property ( // R11
		reg_wr && reg_addr == regctl_pkg::ADDR_DISCHARGE && !restart_now
		|=> rail_discharge == $past(reg_wdata[5:0]))
		else $error("discharge write not applied");
	step_len_a: assert property ( // R16
		cur_ff.st == regctl_pkg::ST_STARTUP && $stable(short_step_select)
		&& cur_ff.step < regctl_pkg::LAST_STEP && cur_ff.tick == 12'h000 ##1
		cur_ff.st == regctl_pkg::ST_STARTUP |-> cur_ff.step == $past(cur_ff.step))
		else $error("time step too short");
	standby_off_a: assert property ( // R7
		cur_ff.st == regctl_pkg::ST_STANDBY |-> rail_on == 6'h00)
		else $error("rail on while in standby");
	start_entry_a: assert property ( // R7
		cur_ff.st == regctl_pkg::ST_STANDBY && cur_ff.pin_sync[regctl_pkg::PIN_EN]
		&& !cur_ff.pin_sync[regctl_pkg::PIN_HOT]
		|=> cur_ff.st == regctl_pkg::ST_STARTUP && cur_ff.step == 3'h0)
		else $error("enable pin did not start the sequence");
	hot_entry_a: assert property ( // R14
		cur_ff.pin_sync[regctl_pkg::PIN_HOT] |=> overheat_shutdown_flag && rail_on == 6'h00)
		else $error("overheat did not shut down");
	cool_standby_a: assert property ( // R12
		cur_ff.st == regctl_pkg::ST_OVERHEAT && !cur_ff.pin_sync[regctl_pkg::PIN_HOT]
		&& cur_ff.pin_sync[regctl_pkg::PIN_COOL] && !cur_ff.pin_sync[regctl_pkg::PIN_EN]
		|=> cur_ff.st == regctl_pkg::ST_STANDBY)
		else $error("cooled without enable pin did not return to standby");
	warn_rise_a: assert property ( // R15
		$rose(overheat_warning_flag) |-> $past(warning_pin, 2))
		else $error("warning flag rose without the pin");

endmodule : regulator_control_registers

// ### verilog/voltage_decode.sv
`timescale 1ns/1ns
module voltage_decode (
	input wire logic clk_sys,
	input wire logic rst_n,
	voltage_if.dec vif
);

	always_comb begin
		vif.external = 1'b0;
		unique case (vif.table_sel)
			regctl_pkg::TBL_MAIN: begin
				vif.level = regctl_pkg::MAIN_TABLE[vif.code]; // R1
			end
			regctl_pkg::TBL_LOW: begin
				vif.level = regctl_pkg::LOW_TABLE[vif.code]; // R2
			end
			regctl_pkg::TBL_SWITCHER: begin
				vif.external = (vif.code == regctl_pkg::SWITCHER_EXT_CODE); // R3
				vif.level = vif.external ? 9'h000 : 9'(regctl_pkg::SWITCHER_BASE
					+ regctl_pkg::SWITCHER_STEP * {4'h0, vif.code}); // R3
			end
			default: begin
				vif.level = 9'h000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	main_ends_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
		(vif.table_sel == regctl_pkg::TBL_MAIN) |->
		((vif.code == 5'h00) -> (vif.level == 9'h078)) &&
		((vif.code == 5'h1f) -> (vif.level == 9'h14a)))
		else $error("main table end points wrong");
	low_ends_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
		(vif.table_sel == regctl_pkg::TBL_LOW) |->
		((vif.code == 5'h00) -> (vif.level == 9'h050)) &&
		((vif.code == 5'h1f) -> (vif.level == 9'h11d)))
		else $error("low table end points wrong");
	switcher_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
		(vif.table_sel == regctl_pkg::TBL_SWITCHER && vif.code != 5'h00) |->
		(!vif.external && vif.level == 9'(9'h04b + 9'h005 * {4'h0, vif.code})))
		else $error("switcher code does not give 50 mV steps");
	switcher_ext_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
		(vif.table_sel == regctl_pkg::TBL_SWITCHER && vif.code == 5'h00) |->
		vif.external)
		else $error("switcher code zero does not select the divider");

endmodule : voltage_decode

// ### verilog/voltage_if.sv
`timescale 1ns/1ns
interface voltage_if;
	logic [4:0] code;
	regctl_pkg::table_e table_sel;
	logic [8:0] level;
	logic external;
	modport src (output code, output table_sel, input level, input external);
	modport dec (input code, input table_sel, output level, output external);
endinterface : voltage_if
